// [sapr_pkg.sv]
// package: constants and state codes for the converter control block
`default_nettype none
package sapr_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 400;
  // longest time rounds down
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int RECOVER_TIME_NS = 20;
  // least time rounds up
  localparam int RECOVER_CYCLES = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ------------------------------------------------------------
  // widths and values
  // ------------------------------------------------------------
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 2;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] TRIAL_START = 16'h8000;
  localparam logic [15:0] SIGN_FLIP = 16'h8000;
  localparam logic [7:0] LOW_LANE_FILL = 8'hFF;
  // idle levels of {start, select, read, byte select} held by the pin stages in reset
  localparam logic [3:0] PIN_IDLE = 4'hE;
  // ------------------------------------------------------------
  // control states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RECOVER = 2'b00,
    ST_IDLE = 2'b01,
    ST_CONVERT = 2'b10,
    ST_STORE = 2'b11
  } sapr_state_type;
endpackage
`default_nettype wire

// [sapr_adc_ctrl.sv]
// module: conversion sequencing, result buffer and parallel readout
//
// Notes on behaviour
// - conversion timed by own clock, no external clock, done within 400 ns; here busy stays high 17 clk_sys cycles, 425 ns.
// - start strobe fall leaves sample mode, enters hold, captures input.
// - busy rises after start strobe falls, stays high, drops when conversion ends.
// - with busy low, sampling runs while chip select low or from its fall.
// - output lanes driven only when chip select and read both low.
// - result is two's complement: 7FFF top, 0000 zero, FFFF, 8000 bottom.
// - one code step is twice the reference over 65536.
// - half-word select low shows all sixteen result bits, msb first.
// - half-word select high puts low byte on upper lanes, lower lanes ones.
// - two-part read works with read toggling or held low.
// - reset aborts conversion at once and clears output latches to zero.
// - first sampling 20 ns after reset; later after busy and select fall.
// - start fall with select low during conversion causes self-clearing reset.
// - chip select fall during conversion causes self-clearing reset.
`timescale 1ns/1ps
`default_nettype none
module sapr_adc_ctrl
  import sapr_pkg::*;
#(
  parameter int RES_W = RESULT_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start_strobe_n,
  input wire logic cs_n,
  input wire logic rd_n,
  input wire logic byte_sel,
  input wire logic cmp_above,
  output logic busy,
  output logic sample_mode,
  output logic [RES_W-1:0] dac_code,
  output logic [RES_W-1:0] output_lanes_out,
  output logic output_lanes_oe_n
);
  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] prev;
    sapr_state_type state;
    logic [3:0] bit_idx;
    logic [3:0] recov_cnt;
    logic [RES_W-1:0] trial;
    logic [FIFO_DEPTH-1:0][RES_W-1:0] mem;
    logic wptr;
    logic rptr;
    logic [1:0] cnt;
    logic [RES_W-1:0] latch;
    logic [RES_W-1:0] lanes;
    logic oe_n;
    logic sample;
    logic busy;
  } sapr_regs_type;

  sapr_regs_type state_reg;
  sapr_regs_type state_next;

  logic strobe_fall;
  logic cs_low;
  logic cs_fall;
  logic rd_low;
  logic bsel;
  logic abort;
  logic push;
  logic pop;
  logic fifo_in_ready;
  logic fifo_out_ready;

  // ------------------------------------------------------------
  // pin decode after the synchroniser
  // ------------------------------------------------------------
  assign strobe_fall = state_reg.prev[3] & ~state_reg.sync2[3];
  assign cs_low = ~state_reg.sync2[2];
  assign cs_fall = state_reg.prev[2] & ~state_reg.sync2[2];
  assign rd_low = ~state_reg.sync2[1];
  assign bsel = state_reg.sync2[0];
  // a second strobe or a new select during a conversion throws it away
  assign abort = (state_reg.state == ST_CONVERT || state_reg.state == ST_STORE) &&
                 ((strobe_fall && cs_low) || cs_fall);
  // the latch only loads from the buffer while the host is not holding the bus in a read
  assign fifo_in_ready = (state_reg.cnt < 2'(FIFO_DEPTH));
  assign fifo_out_ready = ~(cs_low & rd_low);
  assign push = (state_reg.state == ST_STORE) && fifo_in_ready;
  assign pop = (state_reg.cnt != 2'd0) && fifo_out_ready;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.sync1 = {start_strobe_n, cs_n, rd_n, byte_sel};
    state_next.sync2 = state_reg.sync1;
    state_next.prev = state_reg.sync2;
    case (state_reg.state)
      ST_RECOVER: begin
        // short quiet time before the first sampling period
        if (state_reg.recov_cnt == 4'(RECOVER_CYCLES - 1)) begin
          state_next.state = ST_IDLE;
        end else begin
          state_next.recov_cnt = state_reg.recov_cnt + 4'd1;
        end
      end
      ST_IDLE: begin
        state_next.sample = cs_low;
        if (strobe_fall && cs_low) begin
          state_next.state = ST_CONVERT;
          state_next.sample = 1'b0;
          state_next.busy = 1'b1;
          state_next.trial = TRIAL_START;
          state_next.bit_idx = 4'(RES_W - 1);
        end
      end
      ST_CONVERT: begin
        // one bit per clock: RES_W cycles fit in the conversion time
        if (!cmp_above) begin
          state_next.trial[state_reg.bit_idx] = 1'b0;
        end
        if (state_reg.bit_idx == 4'd0) begin
          state_next.state = ST_STORE;
        end else begin
          state_next.trial[state_reg.bit_idx - 4'd1] = 1'b1;
          state_next.bit_idx = state_reg.bit_idx - 4'd1;
        end
      end
      ST_STORE: begin
        // busy stays up while the buffer is full, so no word is lost
        if (push) begin
          // dac steps are twice the reference over 2**RES_W; flip msb for sign
          state_next.mem[state_reg.wptr] = state_reg.trial ^ SIGN_FLIP;
          state_next.wptr = ~state_reg.wptr;
          state_next.busy = 1'b0;
          state_next.state = ST_IDLE;
        end
      end
      default: begin
        state_next.state = ST_RECOVER;
      end
    endcase
    if (pop) begin
      state_next.latch = state_reg.mem[state_reg.rptr];
      state_next.rptr = ~state_reg.rptr;
    end
    state_next.cnt = state_reg.cnt + 2'(push) - 2'(pop);
    // lanes follow byte_sel every cycle, so a held read also works
    if (bsel) begin
      state_next.lanes = {state_reg.latch[BYTE_W-1:0], LOW_LANE_FILL};
    end else begin
      state_next.lanes = state_reg.latch;
    end
    state_next.oe_n = ~(cs_low & rd_low);
    if (abort) begin
      // clears state, busy, sampling, buffer pointers and latch like the reset pin, but no release needed
      state_next.state = ST_RECOVER;
      state_next.recov_cnt = 4'd0;
      state_next.busy = 1'b0;
      state_next.sample = 1'b0;
      state_next.cnt = 2'd0;
      state_next.wptr = 1'b0;
      state_next.rptr = 1'b0;
      state_next.latch = RESULT_RESET;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      // aborts on the edge of reset itself, well inside 50 ns
      state_reg <= '0;
      // pin stages read idle, so release shows no false edge and no bus drive
      state_reg.sync1 <= PIN_IDLE;
      state_reg.sync2 <= PIN_IDLE;
      state_reg.prev <= PIN_IDLE;
      state_reg.oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign busy = state_reg.busy;
  assign sample_mode = state_reg.sample;
  assign dac_code = state_reg.trial;
  assign output_lanes_out = state_reg.lanes;
  assign output_lanes_oe_n = state_reg.oe_n;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_START_BUSY: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg.state == ST_IDLE && strobe_fall && cs_low) |=> busy ##1 (busy || $past(abort)))
    else $error("busy not raised after start");
  AST_START_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg.state == ST_IDLE && strobe_fall && cs_low) |=> !sample_mode)
    else $error("sampling continues after start");
  AST_CONV_LEN: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg.state == ST_IDLE && strobe_fall && cs_low) |->
    ##[1:17] (state_reg.state == ST_STORE || state_reg.state == ST_RECOVER))
    else $error("conversion not finished in time");
  AST_BUSY_END: assert property (@(posedge clk_sys) disable iff (rst)
    (push && !abort) |=> !busy &&
    $past(state_reg.trial) == (state_reg.mem[$past(state_reg.wptr)] ^ SIGN_FLIP))
    else $error("busy or stored result wrong at end");
  AST_BUS_ON: assert property (@(posedge clk_sys) disable iff (rst)
    (cs_low && rd_low) |=> !output_lanes_oe_n)
    else $error("bus not driven during read");
  AST_BUS_OFF: assert property (@(posedge clk_sys) disable iff (rst)
    !(cs_low && rd_low) |=> output_lanes_oe_n)
    else $error("bus driven outside read");
  AST_BYTE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
    bsel |=> output_lanes_out == {$past(state_reg.latch[7:0]), LOW_LANE_FILL})
    else $error("byte mode lanes wrong");
  AST_WORD: assert property (@(posedge clk_sys) disable iff (rst)
    !bsel |=> output_lanes_out == $past(state_reg.latch))
    else $error("word mode lanes wrong");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (rst)
    abort |=> state_reg.state == ST_RECOVER && !busy && state_reg.latch == RESULT_RESET)
    else $error("self reset did not clear");
  AST_CS_ABORT: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg.state == ST_CONVERT && cs_fall) |=> !busy)
    else $error("select fall did not abort");
  AST_IGNORE: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg.state == ST_IDLE && strobe_fall && !cs_low) |=> !busy && state_reg.state == ST_IDLE)
    else $error("start taken with select high");
  AST_RECOVER: assert property (@(posedge clk_sys) disable iff (rst)
    (state_reg.state == ST_RECOVER) |=> state_reg.state == ST_IDLE)
    else $error("recovery time wrong");
endmodule // sapr_adc_ctrl
`default_nettype wire

// [sapr_analog_model.sv]
// analog input model seen through the latched comparator
`timescale 1ns/1ps
`default_nettype none
module sapr_analog_model (
  input wire logic [15:0] level,
  input wire logic [15:0] dac_code,
  output logic cmp_above
);
  // ------------------------------------------------------------
  // comparator
  // ------------------------------------------------------------
  // input sits half a step above level so a tie keeps the trial bit; step is 2*vref/65536
  assign cmp_above = (level >= dac_code);
endmodule // sapr_analog_model
`default_nettype wire

// [test_sar_adc_parallel_readout.sv]
// testbench: conversion, two-part readout, abort and reset scenarios
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_parallel_readout;
  import sapr_pkg::*;
  localparam logic [15:0] CODES [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
  logic clk_sys = 0;
  logic rst = 1;
  logic start_strobe_n = 1;
  logic cs_n = 1;
  logic rd_n = 1;
  logic byte_sel = 0;
  logic cmp_above;
  logic busy;
  logic sample_mode;
  logic [15:0] dac_code;
  logic [15:0] lanes_out;
  logic lanes_oe_n;
  logic [15:0] level = 16'h0000;
  wire [15:0] output_lanes = lanes_oe_n ? 16'hZZZZ : lanes_out;
  int n_fail = 0;
  int total_checks = 0;
  always #12.5 clk_sys = ~clk_sys;
  sapr_adc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .start_strobe_n(start_strobe_n),
    .cs_n(cs_n), .rd_n(rd_n), .byte_sel(byte_sel), .cmp_above(cmp_above), .busy(busy),
    .sample_mode(sample_mode), .dac_code(dac_code), .output_lanes_out(lanes_out),
    .output_lanes_oe_n(lanes_oe_n));
  sapr_analog_model far (.level(level), .dac_code(dac_code), .cmp_above(cmp_above));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic go();
    start_strobe_n = 0;
    tick(2);
    start_strobe_n = 1;
  endtask
  // bounded so a stuck busy cannot hang the run
  task automatic settle(output int n);
    n = 0;
    while (busy !== 1'b0 && n < 40) begin
      tick(1);
      n++;
    end
  endtask
  task automatic arm(input logic [15:0] code);
    level = code ^ 16'h8000;
    rd_n = 1;
    byte_sel = 0;
    cs_n = 0;
    tick(3);
    go();
    tick(2);
  endtask
  task automatic convert(input logic [15:0] code);
    int n;
    arm(code);
    check("busy", {15'h0, busy}, 16'h1);
    check("sample_mode", {15'h0, sample_mode}, 16'h0);
    settle(n);
    check("conv_len", 16'(n <= CONV_CYCLES + 1), 16'h1);
    tick(3);
    check("sample_mode", {15'h0, sample_mode}, 16'h1);
  endtask
  task automatic aborted(input string what);
    int n;
    settle(n);
    check(what, 16'(n < 8), 16'h1);
    tick(3);
    rd_n = 0;
    tick(4);
    check("cleared", output_lanes, RESULT_RESET);
    rd_n = 1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_codes();
    foreach (CODES[i]) begin
      convert(CODES[i]);
      check("idle_bus", output_lanes, 16'hZZZZ);
      rd_n = 0;
      tick(4);
      check("word", output_lanes, CODES[i]);
      byte_sel = 1;
      tick(4);
      check("low_byte", output_lanes, {CODES[i][7:0], 8'hFF});
      rd_n = 1;
      tick(4);
      check("released", output_lanes, 16'hZZZZ);
      rd_n = 0;
      tick(4);
      check("low_again", output_lanes, {CODES[i][7:0], 8'hFF});
    end
    $display("done codes");
  endtask
  task automatic t_ignore();
    rd_n = 1;
    cs_n = 1;
    tick(3);
    go();
    tick(4);
    check("busy", {15'h0, busy}, 16'h0);
    $display("done ignore");
  endtask
  task automatic t_abort_cs();
    convert(16'h1234);
    arm(16'h0F0F);
    cs_n = 1;
    tick(3);
    cs_n = 0;
    aborted("abort_cs");
    $display("done abort by select");
  endtask
  task automatic t_abort_start();
    convert(16'h4321);
    arm(16'hF0F0);
    go();
    aborted("abort_start");
    $display("done abort by strobe");
  endtask
  task automatic t_reset();
    convert(16'h5A5A);
    arm(16'h0001);
    rst = 1;
    tick(2);
    check("busy", {15'h0, busy}, 16'h0);
    rst = 0;
    tick(4);
    check("sample_mode", {15'h0, sample_mode}, 16'h1);
    rd_n = 0;
    tick(4);
    check("cleared", output_lanes, RESULT_RESET);
    convert(16'h1111);
    convert(16'h2222);
    rd_n = 0;
    tick(4);
    check("newest", output_lanes, 16'h2222);
    rd_n = 1;
    $display("done reset and back to back");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    tick(10);
    rst = 0;
    tick(4);
    t_codes();
    t_ignore();
    t_abort_cs();
    t_abort_start();
    t_reset();
    conclude();
  end
  // the tests need under 600 cycles; this is a wide margin
  initial begin
    #(25 * 8000);
    n_fail++;
    conclude();
  end
endmodule // test_sar_adc_parallel_readout
`default_nettype wire
